// >>> verilog/phy_mask_socket_mode_regs.v
`timescale 1ns/1ps
`include "phy_mask_socket_mode_defs.vh"

module phy_mask_socket_mode_regs (
    input wire clk,
    input wire srst,
    input wire [15:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire link_up_pin,
    input wire ip_conflict_event,
    input wire pppoe_close_event,
    output wire interrupt_out_low,
    output wire phy_power_save,
    output wire phy_sleep_control,
    output reg [31:0] socket_protocol,
    output reg [7:0] multicast_active,
    output reg [7:0] frame_filter_enable,
    output reg [7:0] immediate_ack_enable,
    output reg [7:0] igmp_version_select
);

    reg link_meta;
    reg link_sync;
    reg [7:0] phy_link_power_state;
    reg [7:0] extra_interrupt_mask;
    reg [7:0] interrupt_status_flags;
    reg [7:0] socket_mode_config [0:7];
    reg [31:0] eff_code;
    reg [7:0] next_phy;
    reg [7:0] next_mask;
    reg [7:0] next_rdata;
    reg [7:0] next_flags;
    reg [31:0] next_protocol;
    reg [7:0] next_multicast;
    reg [7:0] next_filter;
    reg [7:0] next_ack;
    reg [7:0] next_igmp;
    wire [7:0] irq_pending;
    wire sel_phy;
    wire sel_mask;
    wire sel_flags;
    wire sel_mode;
    wire [2:0] mode_sock;
    wire wr_phy;
    wire wr_mask;
    wire wr_flags;
    wire wr_mode;
    integer i;
    integer j;
    integer k;

    // socket mode address match
    function is_mode_addr;
        input [15:0] a;
        reg [15:0] base;
        begin
            base = `ADDR_MODE_BASE;
            is_mode_addr = (a[15:11] == base[15:11]) && (a[7:0] == 8'h00);
        end
    endfunction

    // protocol code as honoured by a given socket
    function [3:0] eff_proto;
        input [2:0] sock;
        input [3:0] code;
        begin
            if (code <= `PROTO_IP_RAW_MODE)
                eff_proto = code;
            else if (sock == 3'h0 && code <= `PROTO_PPPOE)
                eff_proto = code;
            else
                eff_proto = `PROTO_CLOSED;
        end
    endfunction

    // register address decode
    assign sel_phy = (reg_addr == `ADDR_PHY_STATE);
    assign sel_mask = (reg_addr == `ADDR_EXTRA_MASK);
    assign sel_flags = (reg_addr == `ADDR_STATUS_FLAGS);
    assign sel_mode = is_mode_addr(reg_addr);
    assign mode_sock = reg_addr[10:8];
    // write strobes
    assign wr_phy = reg_wr && sel_phy;
    assign wr_mask = reg_wr && sel_mask;
    assign wr_flags = reg_wr && sel_flags;
    assign wr_mode = reg_wr && sel_mode;

    // link pin synchroniser
    always @(posedge clk) begin
        if (srst) begin
            link_meta <= 1'b0;
            link_sync <= 1'b0;
        end else begin
            link_meta <= link_up_pin;
            link_sync <= link_meta;
        end
    end

    // next phy status and mask
    always @* begin
        next_phy = phy_link_power_state;
        next_mask = extra_interrupt_mask;
        if (wr_phy)
            next_phy = reg_wdata & `PHY_WR_MASK;
        if (wr_mask)
            next_mask = reg_wdata & `MASK_WR_MASK;
    end

    // phy status and mask
    always @(posedge clk) begin
        if (srst) begin
            phy_link_power_state <= `PHY_RESET;
            extra_interrupt_mask <= `MASK_RESET;
        end else begin
            phy_link_power_state <= next_phy;
            extra_interrupt_mask <= next_mask;
        end
    end

    // status flags, write one to clear, set wins
    always @* begin
        next_flags = interrupt_status_flags;
        if (wr_flags)
            next_flags = next_flags & ~(reg_wdata & `MASK_WR_MASK);
        if (ip_conflict_event)
            next_flags[`IRQ_CONFLICT_BIT] = 1'b1;
        if (pppoe_close_event)
            next_flags[`IRQ_PPPOE_BIT] = 1'b1;
    end

    // flag register
    always @(posedge clk) begin
        if (srst)
            interrupt_status_flags <= `FLAGS_RESET;
        else
            interrupt_status_flags <= next_flags;
    end

    // socket mode registers
    always @(posedge clk) begin
        if (srst) begin
            for (i = 0; i < 8; i = i + 1) begin
                socket_mode_config[i] <= `MODE_RESET;
            end
        end else if (wr_mode) begin
            socket_mode_config[mode_sock] <= reg_wdata & `MODE_WR_MASK;
        end
    end

    // read mux
    always @* begin
        next_rdata = 8'h00;
        if (sel_phy) begin
            next_rdata = phy_link_power_state;
            next_rdata[`PHY_LINK_BIT] = link_sync;
        end else if (sel_mask)
            next_rdata = extra_interrupt_mask;
        else if (sel_flags)
            next_rdata = interrupt_status_flags;
        else if (sel_mode)
            next_rdata = socket_mode_config[mode_sock];
    end

    // read data register
    always @(posedge clk) begin
        if (srst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= next_rdata;
    end

    // effective protocol per socket
    always @* begin
        eff_code = 32'h00000000;
        for (j = 0; j < 8; j = j + 1) begin
            eff_code[j*4 +: 4] = eff_proto(j[2:0], socket_mode_config[j][3:0]);
        end
    end

    // next values of the per socket controls
    always @* begin
        next_protocol = eff_code;
        next_multicast = 8'h00;
        next_filter = 8'h00;
        next_ack = 8'h00;
        next_igmp = 8'h00;
        for (k = 0; k < 8; k = k + 1) begin
            next_multicast[k] = socket_mode_config[k][`MODE_MULTI_BIT]
                && eff_code[k*4 +: 4] == `PROTO_UDP;
            next_filter[k] = socket_mode_config[k][`MODE_FILTER_BIT]
                && eff_code[k*4 +: 4] == `PROTO_FRAME_RAW;
            next_ack[k] = socket_mode_config[k][`MODE_ACK_BIT]
                && eff_code[k*4 +: 4] == `PROTO_TCP;
            next_igmp[k] = socket_mode_config[k][`MODE_ACK_BIT]
                && next_multicast[k];
        end
    end

    // registered per socket outputs
    always @(posedge clk) begin
        if (srst) begin
            socket_protocol <= 32'h00000000;
            multicast_active <= 8'h00;
            frame_filter_enable <= 8'h00;
            immediate_ack_enable <= 8'h00;
            igmp_version_select <= 8'h00;
        end else begin
            socket_protocol <= next_protocol;
            multicast_active <= next_multicast;
            frame_filter_enable <= next_filter;
            immediate_ack_enable <= next_ack;
            igmp_version_select <= next_igmp;
        end
    end

    // any unmasked flag holds the interrupt pin low
    assign irq_pending = interrupt_status_flags & extra_interrupt_mask;
    assign phy_power_save = phy_link_power_state[`PHY_SAVE_BIT];
    assign phy_sleep_control = phy_link_power_state[`PHY_DOWN_BIT];
    assign interrupt_out_low = ~|irq_pending;

endmodule // phy_mask_socket_mode_regs

// >>> verilog/phy_mask_socket_mode_defs.vh
// Notes on behaviour
// - bit 5 of the phy status register is read only and shows the link, 1 up and 0 down.
// - bit 4 of the phy status register is read/write and 1 enables phy power save.
// - bit 3 of the phy status register is read/write, 1 powers the phy down and reads back.
// - power save reads 1 after reset and the host clears it for partners that cannot cope.
// - extra mask bit 7 gates the ip conflict flag and bit 5 the pppoe close flag.
// - an interrupt is issued for a set flag whose mask bit is 1 and never when it is 0.
// - eight socket mode registers sit at the base plus socket number times the stride.
// - mode bit 7 enables multicast, effective only when the protocol is udp.
// - in mac raw mode bit 6 set accepts only own or broadcast frames, clear accepts all.
// - in tcp mode bit 5 set acks each data segment at once, clear uses delayed ack.
// - with multicast in udp mode bit 5 picks igmp version, 0 version 2 and 1 version 1.
// - codes 0100 mac raw and 0101 pppoe are honoured only in socket 0.
// - the low active interrupt pin stays low while any unmasked flag is set.
`ifndef PHY_MASK_SOCKET_MODE_DEFS_VH
`define PHY_MASK_SOCKET_MODE_DEFS_VH

`define ADDR_STATUS_FLAGS 16'h0015
`define ADDR_PHY_STATE 16'h0035
`define ADDR_EXTRA_MASK 16'h0036
`define ADDR_MODE_BASE 16'h4000
`define MODE_STRIDE 16'h0100

`define PHY_LINK_BIT 5
`define PHY_SAVE_BIT 4
`define PHY_DOWN_BIT 3
`define PHY_RESET 8'h10
`define PHY_WR_MASK 8'h18

`define IRQ_CONFLICT_BIT 7
`define IRQ_PPPOE_BIT 5
`define MASK_WR_MASK 8'ha0
`define MASK_RESET 8'h00
`define FLAGS_RESET 8'h00

`define MODE_MULTI_BIT 7
`define MODE_FILTER_BIT 6
`define MODE_ACK_BIT 5
`define MODE_WR_MASK 8'hef
`define MODE_RESET 8'h00

`define PROTO_CLOSED 4'h0
`define PROTO_TCP 4'h1
`define PROTO_UDP 4'h2
`define PROTO_IP_RAW_MODE 4'h3
`define PROTO_FRAME_RAW 4'h4
`define PROTO_PPPOE 4'h5

`endif

// >>> testbench/phy_side_model.sv
`timescale 1ns/1ps
module phy_side_model (
    input wire clk,
    output reg link_up_pin,
    output reg ip_conflict_event,
    output reg pppoe_close_event
);
    initial {link_up_pin, ip_conflict_event, pppoe_close_event} = 3'h0;
    // one-cycle event pulses
    task fire(input [1:0] w);
        begin
            @(negedge clk) {ip_conflict_event, pppoe_close_event} = w;
            @(negedge clk) {ip_conflict_event, pppoe_close_event} = 2'h0;
        end
    endtask
endmodule // phy_side_model

// >>> testbench/regs_chk.sv
`timescale 1ns/1ps
module regs_chk (
    input wire clk,
    input wire srst,
    input wire [15:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire interrupt_out_low,
    input wire phy_power_save,
    input wire phy_sleep_control,
    input wire [31:0] socket_protocol,
    input wire [7:0] multicast_active,
    input wire [7:0] frame_filter_enable,
    input wire [7:0] immediate_ack_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire [7:0] p = socket_protocol[7:0];
    rst_state_a: assert property ($fell(srst) |-> interrupt_out_low
        && phy_power_save && !phy_sleep_control) else $error("reset");
    mask_off_a: assert property (reg_wr && reg_addr == 16'h0036
        && reg_wdata == 8'h00 |=> interrupt_out_low) else $error("mask");
    phy_wr_a: assert property (reg_wr && reg_addr == 16'h0035
        |=> {3'h0, phy_power_save, phy_sleep_control, 3'h0} == ($past(reg_wdata) & 8'h18))
        else $error("phy");
    ack_tcp_a: assert property (immediate_ack_enable[0] |-> p[3:0] == 4'h1)
        else $error("ack");
    multi_udp_a: assert property (multicast_active[0] |-> p[3:0] == 4'h2)
        else $error("multi");
    filt_raw_a: assert property (frame_filter_enable != 8'h00
        |-> frame_filter_enable == 8'h01 && p[3:0] == 4'h4) else $error("filter");
    proto_range_a: assert property (p[7:4] <= 4'h3 && socket_protocol[31:28] <= 4'h3)
        else $error("proto");
    mode_dec_a: assert property (reg_wr && reg_addr == 16'h4000
        && reg_wdata == 8'h21 |=> ##1 immediate_ack_enable[0]) else $error("decode");
endmodule // regs_chk
bind phy_mask_socket_mode_regs regs_chk chk_i (.clk, .srst, .reg_addr, .reg_wr, .reg_wdata,
    .interrupt_out_low, .phy_power_save, .phy_sleep_control, .socket_protocol,
    .multicast_active, .frame_filter_enable, .immediate_ack_enable);

// >>> testbench/phy_mask_socket_mode_regs_test.sv
`timescale 1ns/1ps
module phy_mask_socket_mode_regs_test;
    reg clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0;
    reg [15:0] reg_addr = 16'h0000;
    reg [7:0] reg_wdata = 8'h00;
    reg [31:0] r = 32'h0000f38d;
    wire link_up_pin, ip_conflict_event, pppoe_close_event, interrupt_out_low;
    wire phy_power_save, phy_sleep_control;
    wire [31:0] socket_protocol;
    wire [7:0] reg_rdata, multicast_active, frame_filter_enable, immediate_ack_enable;
    wire [7:0] igmp_version_select;
    logic [7:0] q[$];
    int mismatches = 0, total_checks = 0;
    initial forever #12.5 clk = ~clk;
    phy_side_model phy (.clk, .link_up_pin, .ip_conflict_event, .pppoe_close_event);
    phy_mask_socket_mode_regs uut (.clk, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
        .reg_rdata, .link_up_pin, .ip_conflict_event, .pppoe_close_event, .interrupt_out_low,
        .phy_power_save, .phy_sleep_control, .socket_protocol, .multicast_active,
        .frame_filter_enable, .immediate_ack_enable, .igmp_version_select);
    function [31:0] xs(input [31:0] x);
        begin
            x = x ^ (x << 13);
            x = x ^ (x >> 17);
            xs = x ^ (x << 5);
        end
    endfunction
    task automatic chk(input [31:0] s, input [31:0] e);
        begin
            total_checks++;
            if (s !== e) begin
                mismatches++;
                $display("BAD %0t %h %h", $time, s, e);
            end
        end
    endtask
    task wr(input [15:0] a, input [7:0] d);
        begin
            @(negedge clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
            @(negedge clk) reg_wr = 1'b0;
        end
    endtask
    task rd(input [15:0] a, input [7:0] e);
        begin
            @(negedge clk) {reg_addr, reg_rd} = {a, 1'b1};
            q.push_back(e);
            @(negedge clk) reg_rd = 1'b0;
        end
    endtask
    always @(posedge clk) rd_q <= reg_rd;
    always @(negedge clk) if (rd_q) chk(reg_rdata, q.pop_front());
    task md(input [2:0] s, input [7:0] v);
        reg [3:0] c;
        begin
            c = (v[3:0] < 4 || (s == 0 && v[3:0] < 6)) ? v[3:0] : 4'h0;
            wr({5'h08, s, 8'h00}, v);
            rd({5'h08, s, 8'h00}, v & 8'hef);
            chk(socket_protocol[4*s+:4], c);
            chk(multicast_active[s], v[7] && c == 2);
            chk(frame_filter_enable[s], v[6] && c == 4);
            chk(immediate_ack_enable[s], v[5] && c == 1);
            chk(igmp_version_select[s], v[7] && v[5] && c == 2);
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", total_checks, mismatches);
            if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        repeat (3) @(negedge clk);
        srst = 1'b0;
        rd(16'h0035, 8'h10);
        chk({phy_power_save, phy_sleep_control}, 2'h2);
        phy.link_up_pin = 1'b1;
        repeat (4) @(negedge clk);
        rd(16'h0035, 8'h30);
        wr(16'h0035, 8'hff);
        rd(16'h0035, 8'h38);
        chk({phy_power_save, phy_sleep_control}, 2'h3);
        wr(16'h0035, 8'h00);
        rd(16'h0035, 8'h20);
        chk({phy_power_save, phy_sleep_control}, 2'h0);
        wr(16'h0036, 8'hff);
        rd(16'h0036, 8'ha0);
        phy.fire(2'h2);
        chk(interrupt_out_low, 1'b0);
        wr(16'h0015, 8'h80);
        chk(interrupt_out_low, 1'b1);
        wr(16'h0036, 8'h20);
        phy.fire(2'h2);
        chk(interrupt_out_low, 1'b1);
        phy.fire(2'h1);
        chk(interrupt_out_low, 1'b0);
        wr(16'h0036, 8'h00);
        rd(16'h0015, 8'ha0);
        rd(16'h4801, 8'h00);
        md(0, 8'h21);
        md(0, 8'ha2);
        md(0, 8'h44);
        md(3, 8'h44);
        for (int i = 0; i < 48; i++) begin
            r = xs(r);
            md(i[2:0], {r[7:4], 4'(i % 7)});
        end
        @(negedge clk);
        summarize();
    end
    initial begin
        #50000;
        mismatches++;
        summarize();
    end
endmodule // phy_mask_socket_mode_regs_test
